// *** include/gpio_defs.svh ***
// Register offsets, field positions and reset values of the GPIO ports
`ifndef GPIO_DEFS_SVH
`define GPIO_DEFS_SVH
`define GPIO_OFF_DATA 8'h00
`define GPIO_OFF_SEL 8'h03
`define GPIO_OFF_DIR 8'h06
`define GPIO_OFF_INP 8'h09
`define GPIO_OFF_P1IEN 8'h0C
`define GPIO_OFF_PORT_INT_CONTROL 8'h0D
`define GPIO_OFF_IFG 8'h0E
`define GPIO_OFF_PRIO 8'h11
`define GPIO_PORT_INT_CONTROL_EDGE0 0
`define GPIO_PORT_INT_CONTROL_EDGE1 1
`define GPIO_PORT_INT_CONTROL_EDGE2 2
`define GPIO_PORT_INT_CONTROL_P0LO_IEN 3
`define GPIO_PORT_INT_CONTROL_P0HI_IEN 4
`define GPIO_PORT_INT_CONTROL_P2_IEN 5
`define GPIO_PRIO_P0_LSB 0
`define GPIO_PRIO_P1_LSB 2
`define GPIO_P2_MASK 8'h1F
`define GPIO_P1_PULL_MASK 8'hFC
`define GPIO_RST_BYTE 8'h00
`define GPIO_PRIO_P0_RST 2'h0
`define GPIO_PRIO_P1_RST 4'h0
`endif

// *** include/gpio_pkg.sv ***
// Types shared by the GPIO ports block
package gpio_pkg;
  typedef logic [7:0] gpio_byte_type;
  typedef logic [2:0][7:0] gpio_ports_type;
endpackage

// *** src/gpio_ports.sv ***
// General purpose I/O ports: three ports, pin control, edge flags and DMA triggers
`timescale 1ns/1ps
`include "gpio_defs.svh"
// What this block does
// RL1: Two eight-pin ports, one five-pin port
// RL2: Port data byte and bit addressable
// RL3: Select bit one routes pin to peripheral
// RL4: Reset leaves every pin general purpose input
// RL5: Direction bit one makes pin output
// RL6: Normal data read returns pin levels
// RL7: Bit read-modify-write uses output latch
// RL8: Inputs pulled up; mode bit one removes pull
// RL9: High-drive pins never have a pull
// RL10: Deep sleep holds pin mode and value
// RL11: Input edges raise interrupts, edge selectable
// RL12: One group interrupt enable per port
// RL13: Bit, nibble and port-wide pin enables
// RL14: Edge sets pin flag regardless of enable
// RL15: Writing zero clears a pin flag
// RL16: Software clears pin flag before CPU flag
// RL17: Ports zero and one pulse DMA trigger
// RL18: Only general purpose inputs trigger DMA
// RL19: Ports zero and one reachable by DMA
// RL20: Priority bits settle shared peripheral conflicts
// RL21: Pins synchronised before edge detection
module gpio_ports (
  input wire logic clk,
  input wire logic reset_n,
  // Register port
  input wire logic [7:0] reg_addr,
  input wire gpio_pkg::gpio_byte_type reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic reg_rmw,
  input wire logic bit_wr,
  input wire logic [2:0] bit_sel,
  input wire logic bit_val,
  output gpio_pkg::gpio_byte_type reg_rdata,
  // External data space access for DMA
  input wire logic dma_sel,
  input wire logic dma_wr,
  input wire logic dma_rd,
  input wire gpio_pkg::gpio_byte_type dma_wdata,
  output gpio_pkg::gpio_byte_type dma_rdata,
  // Pins
  input wire gpio_pkg::gpio_ports_type pin_in,
  output gpio_pkg::gpio_ports_type pin_out,
  output gpio_pkg::gpio_ports_type pin_oe,
  output gpio_pkg::gpio_ports_type pull_up_en,
  // Peripheral side
  input wire gpio_pkg::gpio_ports_type periph_out,
  input wire gpio_pkg::gpio_ports_type periph_oe,
  output gpio_pkg::gpio_ports_type periph_in,
  output logic [1:0] port0_peripheral_priority,
  output logic [3:0] port1_peripheral_priority,
  // Power modes
  input wire logic sleep_mode_two,
  input wire logic sleep_mode_three,
  // Interrupts and DMA
  input wire logic port0_group_int_enable,
  input wire logic port1_group_int_enable,
  input wire logic port2_group_int_enable,
  output logic [2:0] cpu_port_int_flag,
  output logic port0_dma_trigger,
  output logic port1_dma_trigger
);
  import gpio_pkg::*;

  localparam int NPORTS = 3;

  gpio_ports_type latch;
  gpio_ports_type port_function_select;
  gpio_ports_type port_direction;
  gpio_ports_type port_input_mode;
  gpio_byte_type port1_bit_int_enables;
  gpio_byte_type port_int_control;
  gpio_ports_type pin_int_flags;
  gpio_ports_type sync_a;
  gpio_ports_type sync_b;
  gpio_ports_type sync_prev;
  gpio_ports_type gpio_in_mask;
  gpio_ports_type edge_set;
  gpio_ports_type transition;
  gpio_ports_type pin_en_mask;
  logic [2:0] group_en;
  logic sleeping;

  function automatic logic hit(input logic [7:0] addr, input logic [7:0] base, input int p);
    hit = (addr == base + 8'(p));
  endfunction

  function automatic gpio_byte_type port_mask(input int p);
    port_mask = (p == 2) ? `GPIO_P2_MASK : 8'hFF;
  endfunction

  // Pending set wins over a software clear
  function automatic gpio_byte_type next_flags(input gpio_byte_type old, input gpio_byte_type set,
                                               input logic clr, input gpio_byte_type wd);
    next_flags = (clr ? (old & wd) : old) | set;
  endfunction

  assign sleeping = sleep_mode_two | sleep_mode_three;
  assign group_en = {port2_group_int_enable, port1_group_int_enable, port0_group_int_enable};

  always_comb begin
    for (int p = 0; p < NPORTS; p++) begin
      gpio_in_mask[p] = ~port_function_select[p] & ~port_direction[p] & port_mask(p); // RL18
      transition[p] = (sync_b[p] ^ sync_prev[p]) & gpio_in_mask[p]; // RL17
      edge_set[p] = (port_int_control[p] ? (sync_prev[p] & ~sync_b[p])
                                         : (~sync_prev[p] & sync_b[p])) & gpio_in_mask[p]; // RL11
    end
    pin_en_mask[0] = {{4{port_int_control[`GPIO_PORT_INT_CONTROL_P0HI_IEN]}},
                      {4{port_int_control[`GPIO_PORT_INT_CONTROL_P0LO_IEN]}}}; // RL13
    pin_en_mask[1] = port1_bit_int_enables; // RL13
    pin_en_mask[2] = {8{port_int_control[`GPIO_PORT_INT_CONTROL_P2_IEN]}} & `GPIO_P2_MASK; // RL13
  end

  // Two-stage pin synchroniser and edge history
  // Runs through reset so the history tracks the pins; no false edge after reset
  always_ff @(posedge clk) begin
    sync_a <= pin_in; // RL21
    sync_b <= sync_a; // RL21
    sync_prev <= sync_b;
  end

  // Output latches: byte, bit and DMA writes
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      latch <= '0;
    end else begin
      for (int p = 0; p < NPORTS; p++) begin
        if (reg_wr && hit(reg_addr, `GPIO_OFF_DATA, p)) begin
          latch[p] <= reg_wdata & port_mask(p); // RL1 RL2
        end else if (bit_wr && hit(reg_addr, `GPIO_OFF_DATA, p)) begin
          latch[p] <= ((latch[p] & ~(8'h01 << bit_sel)) | (8'(bit_val) << bit_sel)) & port_mask(p); // RL2 RL7
        end else if (dma_wr && p < 2 && dma_sel == p[0]) begin
          latch[p] <= dma_wdata; // RL19
        end
      end
    end
  end

  // Configuration registers
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      port_function_select <= '0; // RL4
      port_direction <= '0; // RL4
      port_input_mode <= '0; // RL8
      port1_bit_int_enables <= `GPIO_RST_BYTE;
      port_int_control <= `GPIO_RST_BYTE;
      port0_peripheral_priority <= `GPIO_PRIO_P0_RST;
      port1_peripheral_priority <= `GPIO_PRIO_P1_RST;
    end else if (reg_wr) begin
      for (int p = 0; p < NPORTS; p++) begin
        if (hit(reg_addr, `GPIO_OFF_SEL, p)) begin
          port_function_select[p] <= reg_wdata & port_mask(p); // RL3
        end
        if (hit(reg_addr, `GPIO_OFF_DIR, p)) begin
          port_direction[p] <= reg_wdata & port_mask(p); // RL5
        end
        if (hit(reg_addr, `GPIO_OFF_INP, p)) begin
          port_input_mode[p] <= reg_wdata & port_mask(p); // RL8
        end
      end
      if (reg_addr == `GPIO_OFF_P1IEN) begin
        port1_bit_int_enables <= reg_wdata;
      end
      if (reg_addr == `GPIO_OFF_PORT_INT_CONTROL) begin
        port_int_control <= reg_wdata;
      end
      if (reg_addr == `GPIO_OFF_PRIO) begin
        port0_peripheral_priority <= reg_wdata[`GPIO_PRIO_P0_LSB +: 2]; // RL20
        port1_peripheral_priority <= reg_wdata[`GPIO_PRIO_P1_LSB +: 4]; // RL20
      end
    end
  end

  // Pin interrupt flags
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      pin_int_flags <= '0;
    end else begin
      for (int p = 0; p < NPORTS; p++) begin
        pin_int_flags[p] <= next_flags(pin_int_flags[p], edge_set[p],
                                       reg_wr && hit(reg_addr, `GPIO_OFF_IFG, p), reg_wdata); // RL14 RL15
      end
    end
  end

  // Port interrupt requests towards the CPU
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      cpu_port_int_flag <= '0;
    end else begin
      for (int p = 0; p < NPORTS; p++) begin
        cpu_port_int_flag[p] <= group_en[p] & |(pin_int_flags[p] & pin_en_mask[p]); // RL12 RL13
      end
    end
  end

  // DMA triggers on any general purpose input transition of port 0 or 1
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      port0_dma_trigger <= 1'b0;
      port1_dma_trigger <= 1'b0;
    end else begin
      port0_dma_trigger <= |transition[0]; // RL17 RL18
      port1_dma_trigger <= |transition[1]; // RL17 RL18
    end
  end

  // Pad drive; frozen while in the deep sleep modes
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      pin_out <= '0;
      pin_oe <= '0; // RL4
      pull_up_en <= {port_mask(2), `GPIO_P1_PULL_MASK, 8'hFF}; // RL8 RL9
    end else if (!sleeping) begin // RL10
      for (int p = 0; p < NPORTS; p++) begin
        for (int b = 0; b < 8; b++) begin
          pin_out[p][b] <= port_function_select[p][b] ? periph_out[p][b] : latch[p][b]; // RL3
          pin_oe[p][b] <= port_function_select[p][b] ? periph_oe[p][b] : port_direction[p][b]; // RL3 RL5
        end
        pull_up_en[p] <= gpio_in_mask[p] & ~port_input_mode[p]
                         & ((p == 1) ? `GPIO_P1_PULL_MASK : 8'hFF); // RL8 RL9
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      periph_in <= '0;
    end else begin
      periph_in <= sync_b;
    end
  end

  // Register read data, valid one cycle after the strobe
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      reg_rdata <= '0;
    end else begin
      reg_rdata <= '0;
      if (reg_rd) begin
        for (int p = 0; p < NPORTS; p++) begin
          if (hit(reg_addr, `GPIO_OFF_DATA, p)) begin
            reg_rdata <= (reg_rmw ? latch[p] : sync_b[p]) & port_mask(p); // RL6 RL7
          end
          if (hit(reg_addr, `GPIO_OFF_SEL, p)) begin
            reg_rdata <= port_function_select[p];
          end
          if (hit(reg_addr, `GPIO_OFF_DIR, p)) begin
            reg_rdata <= port_direction[p];
          end
          if (hit(reg_addr, `GPIO_OFF_INP, p)) begin
            reg_rdata <= port_input_mode[p];
          end
          if (hit(reg_addr, `GPIO_OFF_IFG, p)) begin
            reg_rdata <= pin_int_flags[p];
          end
        end
        if (reg_addr == `GPIO_OFF_P1IEN) begin
          reg_rdata <= port1_bit_int_enables;
        end
        if (reg_addr == `GPIO_OFF_PORT_INT_CONTROL) begin
          reg_rdata <= port_int_control;
        end
        if (reg_addr == `GPIO_OFF_PRIO) begin
          reg_rdata <= {2'h0, port1_peripheral_priority, port0_peripheral_priority};
        end
      end
    end
  end

  // DMA read: pin levels of port 0 or 1
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      dma_rdata <= '0;
    end else begin
      dma_rdata <= dma_rd ? sync_b[dma_sel] : 8'h00; // RL19
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  sequence s_dir0_write;
    reg_wr && reg_addr == `GPIO_OFF_DIR && port_function_select[0] == 8'h00 && !sleeping;
  endsequence
  sequence s_dir0_settle;
    !(reg_wr && (reg_addr == `GPIO_OFF_DIR || reg_addr == `GPIO_OFF_SEL)) && !sleeping;
  endsequence

  property p_dir_drives_oe;
    s_dir0_write ##1 s_dir0_settle |=> pin_oe[0] == $past(reg_wdata, 2);
  endproperty
  a_dir_drives_oe: assert property (p_dir_drives_oe) else $error("direction write not on output enable"); // RL5

  property p_reset_input;
    $rose(reset_n) |-> pin_oe == '0 && port_function_select == '0 && pull_up_en[1][1:0] == 2'h0;
  endproperty
  a_reset_input: assert property (p_reset_input) else $error("pins not inputs after reset"); // RL4

  property p_pin_read;
    reg_rd && !reg_rmw && reg_addr == `GPIO_OFF_DATA + 8'h01 |=> reg_rdata == $past(sync_b[1]);
  endproperty
  a_pin_read: assert property (p_pin_read) else $error("data read not pin level"); // RL6

  property p_rmw_read;
    reg_rd && reg_rmw && reg_addr == `GPIO_OFF_DATA + 8'h01 |=> reg_rdata == $past(latch[1]);
  endproperty
  a_rmw_read: assert property (p_rmw_read) else $error("rmw read not latch value"); // RL7

  property p_no_pull_high_drive;
    pull_up_en[1][1:0] == 2'h0;
  endproperty
  a_no_pull_high_drive: assert property (p_no_pull_high_drive) else $error("pull on high-drive pin"); // RL9

  property p_sleep_hold;
    sleeping && $past(sleeping) |-> $stable(pin_out) && $stable(pin_oe) && $stable(pull_up_en);
  endproperty
  a_sleep_hold: assert property (p_sleep_hold) else $error("pins changed during sleep"); // RL10

  property p_flag_set;
    edge_set[1] != 8'h00 |=> (pin_int_flags[1] & $past(edge_set[1])) == $past(edge_set[1]);
  endproperty
  a_flag_set: assert property (p_flag_set) else $error("edge did not set flag"); // RL14

  property p_flag_clear;
    reg_wr && reg_addr == `GPIO_OFF_IFG + 8'h01 && edge_set[1] == 8'h00
      |=> pin_int_flags[1] == ($past(pin_int_flags[1]) & $past(reg_wdata));
  endproperty
  a_flag_clear: assert property (p_flag_clear) else $error("zero write did not clear flag"); // RL15

  property p_dma_trigger;
    port1_dma_trigger == $past(|((sync_b[1] ^ sync_prev[1]) & gpio_in_mask[1]));
  endproperty
  a_dma_trigger: assert property (p_dma_trigger) else $error("dma trigger mismatch"); // RL17

  property p_dma_read;
    dma_rd |=> dma_rdata == $past(sync_b[dma_sel]);
  endproperty
  a_dma_read: assert property (p_dma_read) else $error("dma read wrong"); // RL19
endmodule

// *** verif/gpio_pin_model.sv ***
// Board-side pin model: pads, pull-ups and external drivers
`timescale 1ns/1ps
module gpio_pin_model (
  // Clock
  input wire logic clk,
  // Pads from the block
  input wire gpio_pkg::gpio_ports_type pad_out,
  input wire gpio_pkg::gpio_ports_type pad_oe,
  input wire gpio_pkg::gpio_ports_type pull_en,
  // External drivers
  input wire gpio_pkg::gpio_ports_type ext,
  input wire gpio_pkg::gpio_ports_type ext_en,
  // Resolved pin levels
  output gpio_pkg::gpio_ports_type level
);
  import gpio_pkg::*;
  gpio_ports_type last;
  always_ff @(posedge clk) begin
    last <= level;
  end
  always_comb begin
    for (int p = 0; p < 3; p++) begin
      for (int b = 0; b < 8; b++) begin
        if (pad_oe[p][b]) begin
          level[p][b] = pad_out[p][b];
        end else if (ext_en[p][b]) begin
          level[p][b] = ext[p][b];
        end else if (pull_en[p][b]) begin
          level[p][b] = 1'b1;
        end else begin
          // Floating pad holds no value
          level[p][b] = ~last[p][b];
        end
      end
    end
  end
endmodule

// *** verif/testbench.sv ***
// Self-checking bench for the GPIO ports block
`timescale 1ns/1ps
`include "gpio_defs.svh"
module testbench;
  import gpio_pkg::*;
  logic clk, reset_n, reg_wr, reg_rd, reg_rmw, bit_wr, bit_val;
  logic dma_sel, dma_wr, dma_rd, sleep2, sleep3, ge0, ge1, ge2, trig0, trig1;
  logic [7:0] reg_addr;
  logic [2:0] bit_sel, cpu_flag;
  logic [1:0] pri0;
  logic [3:0] pri1;
  gpio_byte_type reg_wdata, reg_rdata, dma_wdata, dma_rdata;
  gpio_ports_type pin_in, pin_out, pin_oe, pull_up_en, periph_out, periph_oe, periph_in, ext;
  int mismatches = 0;
  int checks = 0;
  int cycles = 0;
  int n0 = 0;
  int n1 = 0;
  typedef struct {logic [7:0] a; gpio_byte_type w; gpio_byte_type e;} gpio_row_type;
  gpio_row_type rows[7];

  gpio_ports u_gpio_ports (.clk(clk), .reset_n(reset_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rmw(reg_rmw), .bit_wr(bit_wr), .bit_sel(bit_sel),
    .bit_val(bit_val), .reg_rdata(reg_rdata), .dma_sel(dma_sel), .dma_wr(dma_wr), .dma_rd(dma_rd),
    .dma_wdata(dma_wdata), .dma_rdata(dma_rdata), .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe),
    .pull_up_en(pull_up_en), .periph_out(periph_out), .periph_oe(periph_oe), .periph_in(periph_in),
    .port0_peripheral_priority(pri0), .port1_peripheral_priority(pri1), .sleep_mode_two(sleep2),
    .sleep_mode_three(sleep3), .port0_group_int_enable(ge0), .port1_group_int_enable(ge1),
    .port2_group_int_enable(ge2), .cpu_port_int_flag(cpu_flag), .port0_dma_trigger(trig0),
    .port1_dma_trigger(trig1));
  gpio_pin_model u_gpio_pin_model (.clk(clk), .pad_out(pin_out), .pad_oe(pin_oe), .pull_en(pull_up_en),
    .ext(ext), .ext_en({24{1'b1}}), .level(pin_in));

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  // Watchdog and trigger pulse counters
  always @(posedge clk) begin
    cycles++;
    if (trig0 === 1'b1) n0++;
    if (trig1 === 1'b1) n1++;
    if (cycles == 2000) begin
      mismatches++;
      summarize();
    end
  end

  task automatic summarize;
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  task automatic chk(input logic [23:0] seen, input logic [23:0] exp);
    checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("Error at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask
  // Byte write, or bit write with d = {value, 4'h0, index}
  task automatic wr(input logic [7:0] a, input gpio_byte_type d, input logic b = 1'b0);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    bit_sel <= d[2:0];
    bit_val <= d[7];
    reg_wr <= !b;
    bit_wr <= b;
    @(posedge clk);
    reg_wr <= 1'b0;
    bit_wr <= 1'b0;
  endtask
  task automatic rc(input logic [7:0] a, input logic m, input gpio_byte_type e);
    @(posedge clk);
    reg_addr <= a;
    reg_rmw <= m;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    reg_rmw <= 1'b0;
    #1 chk(reg_rdata, e);
  endtask

  initial begin
    {reg_wr, reg_rd, reg_rmw, bit_wr, bit_val, dma_sel, dma_wr, dma_rd, sleep2, sleep3} = '0;
    {ge0, ge1, ge2, bit_sel, reg_addr} = '0;
    {reg_wdata, dma_wdata, periph_out, periph_oe, ext} = '0;
    reset_n = 1'b0;
    rows = '{'{8'h08, 8'hFF, 8'h1F}, '{8'h08, 8'h00, 8'h00}, '{8'h0C, 8'hAA, 8'hAA},
      '{8'h0D, 8'h3C, 8'h3C}, '{8'h11, 8'hFF, 8'h3F}, '{8'h20, 8'hFF, 8'h00}, '{8'h0B, 8'hE0, 8'h00}};
    cyc(8);
    reset_n <= 1'b1;
    foreach (rows[i]) begin
      wr(rows[i].a, rows[i].w);
      rc(rows[i].a, 1'b0, rows[i].e);
    end
    chk({pri1, pri0}, 24'h3F);
    $display("done: register rows");
    n0 = 0;
    wr(`GPIO_OFF_DIR, 8'h0F);
    wr(`GPIO_OFF_DATA, 8'hA5);
    ext[0] <= 8'h30;
    cyc(5);
    #1 chk(pin_oe[0], 8'h0F);
    chk(pin_out[0][3:0], 4'h5);
    rc(`GPIO_OFF_DATA, 1'b0, 8'h35);
    rc(`GPIO_OFF_DATA, 1'b1, 8'hA5);
    rc(`GPIO_OFF_IFG, 1'b0, 8'h30);
    chk(24'(n0), 24'h1);
    wr(`GPIO_OFF_DATA, 8'h07, 1'b1);
    rc(`GPIO_OFF_DATA, 1'b1, 8'h25);
    $display("done: direction and latch");
    n1 = 0;
    cyc(1);
    ge1 <= 1'b1;
    ext[1] <= 8'h08;
    cyc(6);
    #1 chk(24'(n1), 24'h1);
    chk(cpu_flag, 3'b010);
    cyc(1);
    ge1 <= 1'b0;
    cyc(2);
    #1 chk(cpu_flag, 3'b000);
    cyc(1);
    ge1 <= 1'b1;
    ext[1] <= 8'h0C;
    cyc(6);
    rc(`GPIO_OFF_IFG + 8'h01, 1'b0, 8'h0C);
    wr(`GPIO_OFF_IFG + 8'h01, 8'hF7);
    cyc(2);
    #1 chk(cpu_flag, 3'b000);
    rc(`GPIO_OFF_IFG + 8'h01, 1'b0, 8'h04);
    cyc(1);
    ge2 <= 1'b1;
    ext[2] <= 8'h01;
    cyc(6);
    rc(`GPIO_OFF_IFG + 8'h02, 1'b0, 8'h00);
    cyc(1);
    ext[2] <= 8'h00;
    cyc(6);
    rc(`GPIO_OFF_IFG + 8'h02, 1'b0, 8'h01);
    chk(cpu_flag[2], 1'b1);
    $display("done: interrupts");
    n1 = 0;
    wr(`GPIO_OFF_SEL + 8'h01, 8'hC0);
    periph_oe[1] <= 8'h80;
    periph_out[1] <= 8'h80;
    ext[1] <= 8'h4C;
    cyc(6);
    #1 chk({pin_oe[1][7], pin_out[1][7], periph_in[1][6]}, 24'h7);
    chk(24'(n1), 24'h0);
    rc(`GPIO_OFF_IFG + 8'h01, 1'b0, 8'h04);
    $display("done: peripheral pins");
    for (int s = 0; s < 2; s++) begin
      cyc(1);
      {sleep3, sleep2} <= 2'b01 << s;
      wr(`GPIO_OFF_DIR, s ? 8'h0F : 8'hF0);
      cyc(3);
      #1 chk(pin_oe[0], s ? 8'hF0 : 8'h0F);
      cyc(1);
      {sleep3, sleep2} <= 2'b00;
      cyc(2);
      #1 chk(pin_oe[0], s ? 8'h0F : 8'hF0);
    end
    $display("done: sleep hold");
    cyc(1);
    dma_sel <= 1'b1;
    dma_rd <= 1'b1;
    cyc(1);
    dma_rd <= 1'b0;
    #1 chk(dma_rdata, 8'hCC);
    cyc(1);
    dma_sel <= 1'b0;
    dma_wdata <= 8'h5A;
    dma_wr <= 1'b1;
    cyc(1);
    dma_wr <= 1'b0;
    rc(`GPIO_OFF_DATA, 1'b1, 8'h5A);
    $display("done: dma access");
    wr(`GPIO_OFF_INP + 8'h02, 8'h03);
    cyc(2);
    #1 chk(pull_up_en[2], 8'h1C);
    cyc(1);
    reset_n <= 1'b0;
    cyc(2);
    #1 chk(pull_up_en, 24'h1FFCFF);
    chk(pin_oe, 24'h0);
    cyc(1);
    reset_n <= 1'b1;
    rc(`GPIO_OFF_SEL + 8'h01, 1'b0, 8'h00);
    rc(`GPIO_OFF_IFG + 8'h01, 1'b0, 8'h00);
    $display("done: second reset");
    summarize();
  end
endmodule
